// ==== rtl/irq_bank.v ====
// Register access over APB and the register addresses were decided locally.
`include "irq_bank_regs.vh"

// Operation
// - edge field: off, rise, fall, both
// - selected pin edge sets pin flag
// - every source has flag and enable
// - control a bit 0 is global enable
// - control a flag and enable bit layout
// - control b flag and enable bit layout
// - group 0 timer0 compare bit layout
// - group 1 holds converter, timer1 bits
// - implemented bits read-write except overtemperature status, reset zero
// - unimplemented bits ignore writes, read zero
// - guarded overtemperature raises read-only status
// - guarded overtemperature sets thermal flag, may interrupt
// - flags set even when disabled
// - servicing clears global enable, flags keep recording
// - servicing thermal or tick clears flag
// - any set flag wakes device
module irq_bank (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        ext_pin,
  input  wire        overtemp_in,
  input  wire        tick0_evt,
  input  wire        tick1_evt,
  input  wire        eeprom_done_evt,
  input  wire        conv_done_evt,
  input  wire        t0_cmp_a_evt,
  input  wire        t0_cmp_p_evt,
  input  wire        t1_cmp_a_evt,
  input  wire        t1_cmp_p_evt,
  input  wire        irq_ack,
  output reg         irq_req,
  output reg  [2:0]  irq_index,
  output reg         wake_req,
  output reg         hv_driver_enable,
  output reg         overtemp_guard_enable
);

  reg  [7:0] edge_q;
  reg  [7:0] ctrl_a_q;
  reg  [7:0] ctrl_b_q;
  reg  [7:0] grp0_q;
  reg  [7:0] grp1_q;
  reg  [7:0] hv_q;
  reg        ovt_status_q;
  reg        pin_prev_q;

  wire       wr_en;
  wire       rd_setup;
  wire       ack_ok;
  wire       pin_rise;
  wire       pin_fall;
  wire       pin_hit;
  wire       ovt_status_d;
  wire       grp0_hit;
  wire       grp1_hit;
  wire [6:0] pend;
  wire       any_pend;
  wire [7:0] set_a;
  wire [7:0] set_b;
  wire [7:0] set_g0;
  wire [7:0] set_g1;
  wire [7:0] clr_a;
  wire [7:0] clr_b;
  reg  [7:0] rd_byte;
  reg        rd_hit;
  wire       wr_edge;
  wire       wr_ctrl_a;
  wire       wr_ctrl_b;
  wire       wr_grp0;
  wire       wr_grp1;
  wire       wr_hv;
  wire       svc_ovt;
  wire       svc_tick0;
  wire       svc_tick1;
  wire [6:0] src_flag;
  wire [6:0] src_en;
  genvar     g;

  // write lands at the edge that closes the access phase
  assign wr_en    = psel & penable & pready & pwrite;
  assign rd_setup = psel & ~penable;
  assign ack_ok   = irq_ack & irq_req;

  // hardware set beats software write and service clear
  function [7:0] next_val;
    input [7:0] cur;
    input       wr;
    input [7:0] wdata;
    input [7:0] mask;
    input [7:0] set;
    input [7:0] clr;
    begin
      next_val = ((((wr ? wdata : cur) & ~clr) | set) & mask);
    end
  endfunction

  function [2:0] prio_pick;
    input [6:0] p;
    integer     k;
    begin
      prio_pick = `SRC_PIN;
      for (k = 6; k >= 0; k = k - 1) begin
        if (p[k]) begin
          prio_pick = k[2:0];
        end
      end
    end
  endfunction

  // register decode shared by the six write strobes
  function reg_sel;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      reg_sel = (addr == ofs);
    end
  endfunction

  function edge_match;
    input [1:0] sel;
    input       rise;
    input       fall;
    begin
      case (sel)
        `EDGE_RISE: begin
          edge_match = rise;
        end
        `EDGE_FALL: begin
          edge_match = fall;
        end
        `EDGE_BOTH: begin
          edge_match = rise | fall;
        end
        default: begin
          edge_match = 1'b0;
        end
      endcase
    end
  endfunction

  // one write strobe per register, all qualified by the completed access
  assign wr_edge   = wr_en & reg_sel(paddr, `OFS_EDGE_SEL);
  assign wr_ctrl_a = wr_en & reg_sel(paddr, `OFS_CTRL_A);
  assign wr_ctrl_b = wr_en & reg_sel(paddr, `OFS_CTRL_B);
  assign wr_grp0   = wr_en & reg_sel(paddr, `OFS_GROUP0);
  assign wr_grp1   = wr_en & reg_sel(paddr, `OFS_GROUP1);
  assign wr_hv     = wr_en & reg_sel(paddr, `OFS_HV_GUARD);

  // service of a source that clears its own flag
  assign svc_ovt   = ack_ok & (irq_index == `SRC_OVT);
  assign svc_tick0 = ack_ok & (irq_index == `SRC_TICK0);
  assign svc_tick1 = ack_ok & (irq_index == `SRC_TICK1);

  assign pin_rise = ext_pin & ~pin_prev_q;
  assign pin_fall = ~ext_pin & pin_prev_q;
  assign pin_hit  = edge_match(edge_q[1:0], pin_rise, pin_fall);

  assign ovt_status_d = hv_q[`HV_GUARD_EN] & overtemp_in;

  assign grp0_hit = (grp0_q[`G0_T0A_FLAG] & grp0_q[`G0_T0A_EN]) |
                    (grp0_q[`G0_T0P_FLAG] & grp0_q[`G0_T0P_EN]);
  assign grp1_hit = (grp1_q[`G1_ADC_FLAG] & grp1_q[`G1_ADC_EN]) |
                    (grp1_q[`G1_T1A_FLAG] & grp1_q[`G1_T1A_EN]) |
                    (grp1_q[`G1_T1P_FLAG] & grp1_q[`G1_T1P_EN]);

  assign set_a = {1'b0, grp0_hit, ovt_status_d & ~ovt_status_q, pin_hit, 4'h0};
  assign set_b = {eeprom_done_evt, tick1_evt, tick0_evt, grp1_hit, 4'h0};
  assign set_g0 = {2'b00, t0_cmp_a_evt, t0_cmp_p_evt, 4'h0};
  assign set_g1 = {1'b0, conv_done_evt, t1_cmp_a_evt, t1_cmp_p_evt, 4'h0};

  // service clears global enable, and thermal or tick flag of the served source
  assign clr_a = {2'b00, svc_ovt, 4'h0, ack_ok};
  assign clr_b = {1'b0, svc_tick1, svc_tick0, 5'h00};

  // source vectors in priority order, bit number equals the source index
  assign src_flag = {ctrl_b_q[`B_EE_FLAG],
                     ctrl_b_q[`B_TICK1_FLAG],
                     ctrl_b_q[`B_TICK0_FLAG],
                     ctrl_b_q[`B_GRP1_FLAG],
                     ctrl_a_q[`A_GRP0_FLAG],
                     ctrl_a_q[`A_OVT_FLAG],
                     ctrl_a_q[`A_PIN_FLAG]};
  assign src_en   = {ctrl_b_q[`B_EE_EN],
                     ctrl_b_q[`B_TICK1_EN],
                     ctrl_b_q[`B_TICK0_EN],
                     ctrl_b_q[`B_GRP1_EN],
                     ctrl_a_q[`A_GRP0_EN],
                     ctrl_a_q[`A_OVT_EN],
                     ctrl_a_q[`A_PIN_EN]};

  // a flag without its enable stays recorded but never requests
  generate
    for (g = 0; g < 7; g = g + 1) begin : gen_pend
      assign pend[g] = src_flag[g] & src_en[g];
    end
  endgenerate
  assign any_pend = |pend;

  always @* begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (paddr)
      `OFS_EDGE_SEL: begin
        rd_byte = edge_q;
      end
      `OFS_CTRL_A: begin
        rd_byte = ctrl_a_q;
      end
      `OFS_CTRL_B: begin
        rd_byte = ctrl_b_q;
      end
      `OFS_GROUP0: begin
        rd_byte = grp0_q;
      end
      `OFS_GROUP1: begin
        rd_byte = grp1_q;
      end
      `OFS_HV_GUARD: begin
        rd_byte = hv_q | {5'h00, ovt_status_q, 2'b00};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // zero-wait apb slave: ready in the first access cycle
  always @(posedge core_clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= rd_setup;
      pslverr <= rd_setup & ~rd_hit;
      if (rd_setup) begin
        prdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // event history: previous pin level and registered over-temperature status
  always @(posedge core_clk) begin
    if (sys_rst) begin
      ovt_status_q <= 1'b0;
      pin_prev_q   <= 1'b0;
    end else begin
      pin_prev_q   <= ext_pin;
      ovt_status_q <= ovt_status_d;
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      edge_q <= `RST_EDGE_SEL;
    end else begin
      edge_q <= next_val(edge_q, wr_edge, pwdata[7:0], `MASK_EDGE_SEL,
                         8'h00, 8'h00);
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_a_q <= `RST_CTRL_A;
    end else begin
      ctrl_a_q <= next_val(ctrl_a_q, wr_ctrl_a, pwdata[7:0], `MASK_CTRL_A,
                           set_a, clr_a);
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_b_q <= `RST_CTRL_B;
    end else begin
      ctrl_b_q <= next_val(ctrl_b_q, wr_ctrl_b, pwdata[7:0], `MASK_CTRL_B,
                           set_b, clr_b);
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      grp0_q <= `RST_GROUP0;
    end else begin
      grp0_q <= next_val(grp0_q, wr_grp0, pwdata[7:0], `MASK_GROUP0,
                         set_g0, 8'h00);
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      grp1_q <= `RST_GROUP1;
    end else begin
      grp1_q <= next_val(grp1_q, wr_grp1, pwdata[7:0], `MASK_GROUP1,
                         set_g1, 8'h00);
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      hv_q <= `RST_HV_GUARD;
    end else begin
      hv_q <= next_val(hv_q, wr_hv, pwdata[7:0], `MASK_HV_GUARD,
                       8'h00, 8'h00);
    end
  end

  // request to the core, dropped on the acknowledge edge
  always @(posedge core_clk) begin
    if (sys_rst) begin
      irq_req               <= 1'b0;
      irq_index             <= `SRC_PIN;
      wake_req              <= 1'b0;
    end else begin
      irq_req   <= ctrl_a_q[`A_GIE] & any_pend & ~ack_ok;
      if (~irq_req | ack_ok) begin
        irq_index <= prio_pick(pend);
      end
      wake_req  <= (|(ctrl_a_q & 8'h70)) | (|(ctrl_b_q & 8'hf0)) |
                   (|(grp0_q & 8'h30)) | (|(grp1_q & 8'h70));
    end
  end

  // driver control pins mirror the guard register; software orders the writes
  always @(posedge core_clk) begin
    if (sys_rst) begin
      hv_driver_enable      <= 1'b0;
      overtemp_guard_enable <= 1'b0;
    end else begin
      hv_driver_enable      <= hv_q[`HV_DRV_EN];
      overtemp_guard_enable <= hv_q[`HV_GUARD_EN];
    end
  end

endmodule // irq_bank

// ==== rtl/irq_bank_regs.vh ====
`ifndef IRQ_BANK_REGS_VH
`define IRQ_BANK_REGS_VH

// register byte offsets on the apb bus
`define OFS_EDGE_SEL      8'h00
`define OFS_CTRL_A        8'h04
`define OFS_CTRL_B        8'h08
`define OFS_GROUP0        8'h0c
`define OFS_GROUP1        8'h10
`define OFS_HV_GUARD      8'h14

// implemented (writable) bits of each register
`define MASK_EDGE_SEL     8'h03
`define MASK_CTRL_A       8'h7f
`define MASK_CTRL_B       8'hff
`define MASK_GROUP0       8'h33
`define MASK_GROUP1       8'h77
`define MASK_HV_GUARD     8'h18

// reset values
`define RST_EDGE_SEL      8'h00
`define RST_CTRL_A        8'h00
`define RST_CTRL_B        8'h00
`define RST_GROUP0        8'h00
`define RST_GROUP1        8'h00
`define RST_HV_GUARD      8'h00

// edge select codes
`define EDGE_OFF          2'b00
`define EDGE_RISE         2'b01
`define EDGE_FALL         2'b10
`define EDGE_BOTH         2'b11

// control a fields
`define A_GIE             0
`define A_PIN_EN          1
`define A_OVT_EN          2
`define A_GRP0_EN         3
`define A_PIN_FLAG        4
`define A_OVT_FLAG        5
`define A_GRP0_FLAG       6

// control b fields
`define B_GRP1_EN         0
`define B_TICK0_EN        1
`define B_TICK1_EN        2
`define B_EE_EN           3
`define B_GRP1_FLAG       4
`define B_TICK0_FLAG      5
`define B_TICK1_FLAG      6
`define B_EE_FLAG         7

// group 0 fields
`define G0_T0P_EN         0
`define G0_T0A_EN         1
`define G0_T0P_FLAG       4
`define G0_T0A_FLAG       5

// group 1 fields
`define G1_T1P_EN         0
`define G1_T1A_EN         1
`define G1_ADC_EN         2
`define G1_T1P_FLAG       4
`define G1_T1A_FLAG       5
`define G1_ADC_FLAG       6

// high-voltage guard register fields
`define HV_OVT_STATUS     2
`define HV_GUARD_EN       3
`define HV_DRV_EN         4

// source indices, lowest index has highest priority
`define SRC_PIN           3'd0
`define SRC_OVT           3'd1
`define SRC_GRP0          3'd2
`define SRC_GRP1          3'd3
`define SRC_TICK0         3'd4
`define SRC_TICK1         3'd5
`define SRC_EE            3'd6

`endif

// ==== verif/interrupt_flag_enable_bank_test.sv ====
module interrupt_flag_enable_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, sys_rst, psel, penable, pwrite, ext_pin, overtemp_in, pready, pslverr;
  logic irq_ack, irq_req, wake_req, hv_en, guard_en;
  logic [7:0] paddr, ev, ad[6], wv[6], ex[6];
  logic [31:0] pwdata, prdata;
  logic [2:0] irq_index, last_index;
  int n_fail, compares;
  irq_bank dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_pin(ext_pin), .overtemp_in(overtemp_in), .tick0_evt(ev[0]),
    .tick1_evt(ev[1]), .eeprom_done_evt(ev[2]), .conv_done_evt(ev[3]), .t0_cmp_a_evt(ev[4]),
    .t0_cmp_p_evt(ev[5]), .t1_cmp_a_evt(ev[6]), .t1_cmp_p_evt(ev[7]), .irq_ack(irq_ack),
    .irq_req(irq_req), .irq_index(irq_index), .wake_req(wake_req),
    .hv_driver_enable(hv_en), .overtemp_guard_enable(guard_en));
  irq_core_model core (.core_clk(core_clk), .sys_rst(sys_rst), .irq_req(irq_req),
    .irq_index(irq_index), .irq_ack(irq_ack), .last_index(last_index));
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    int n;
    n = 0;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1 && ++n < 50);
    chk("ready", pready, 1'b1);
    if (!w) chk("read data", prdata[7:0], e);
    chk("error flag", pslverr, a > 8'h14);
    {psel, penable} <= 2'b00;
  endtask
  task pulse(input int i);
    @(posedge core_clk);
    ev <= 8'h01 << i;
    @(posedge core_clk);
    ev <= 8'h00;
  endtask
  task t_regs;
    ad = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    wv = '{8'hff, 8'hfe, 8'hff, 8'hff, 8'hff, 8'hef};
    ex = '{8'h03, 8'h7e, 8'hff, 8'h33, 8'h77, 8'h08};
    foreach (ad[i]) apb(0, ad[i], 0, 8'h00);
    foreach (ad[i]) begin
      apb(1, ad[i], wv[i], 0);
      apb(0, ad[i], 0, ex[i]);
    end
    for (int i = 5; i >= 0; i--) apb(1, ad[i], 8'h00, 0);
    apb(0, 8'h18, 0, 8'h00);
  endtask
  task t_edges;
    for (int c = 0; c < 4; c++) begin
      apb(1, 8'h00, c, 0);
      apb(1, 8'h04, 0, 0);
      ext_pin <= 1'b1;
      apb(0, 8'h04, 0, c[0] ? 8'h10 : 8'h00);
      apb(1, 8'h04, 0, 0);
      ext_pin <= 1'b0;
      apb(0, 8'h04, 0, c[1] ? 8'h10 : 8'h00);
      apb(1, 8'h04, 0, 0);
    end
    apb(1, 8'h00, 0, 0);
  endtask
  task t_thermal;
    apb(1, 8'h14, 8'h08, 0);
    apb(1, 8'h14, 8'h18, 0);
    repeat (2) @(posedge core_clk);
    chk("driver enables", {hv_en, guard_en}, 2'b11);
    overtemp_in <= 1'b1;
    apb(0, 8'h14, 0, 8'h1c);
    apb(0, 8'h04, 0, 8'h20);
    overtemp_in <= 1'b0;
    apb(1, 8'h14, 8'h10, 0);
    apb(1, 8'h14, 8'h00, 0);
    apb(1, 8'h04, 8'h00, 0);
  endtask
  task t_events;
    for (int i = 0; i < 8; i++) pulse(i);
    apb(0, 8'h08, 0, 8'he0);
    apb(0, 8'h0c, 0, 8'h30);
    apb(0, 8'h10, 0, 8'h70);
    chk("wake", wake_req, 1'b1);
    for (int i = 4; i >= 2; i--) apb(1, ad[i], 8'h00, 0);
    repeat (3) @(posedge core_clk);
    chk("wake idle", wake_req, 1'b0);
  endtask
  task t_service;
    apb(1, 8'h08, 8'h02, 0);
    apb(1, 8'h04, 8'h01, 0);
    pulse(0);
    repeat (8) @(posedge core_clk);
    chk("served index", last_index, 3'd4);
    apb(0, 8'h08, 0, 8'h02);
    apb(0, 8'h04, 0, 8'h00);
    apb(1, 8'h0c, 8'h01, 0);
    apb(1, 8'h04, 8'h08, 0);
    pulse(5);
    apb(0, 8'h04, 0, 8'h48);
    apb(0, 8'h0c, 0, 8'h11);
  endtask
  task t_reset;
    apb(1, 8'h08, 8'hff, 0);
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    apb(0, 8'h08, 0, 8'h00);
    apb(0, 8'h04, 0, 8'h00);
  endtask
  task t_prio;
    apb(1, 8'h00, 8'h01, 0);
    apb(1, 8'h08, 8'h02, 0);
    pulse(0);
    ext_pin <= 1'b1;
    apb(1, 8'h04, 8'h13, 0);
    repeat (8) @(posedge core_clk);
    chk("first served", last_index, 3'd0);
    apb(0, 8'h08, 0, 8'h22);
    apb(1, 8'h04, 8'h03, 0);
    repeat (8) @(posedge core_clk);
    chk("second served", last_index, 3'd4);
    apb(0, 8'h08, 0, 8'h02);
    apb(0, 8'h04, 0, 8'h02);
    apb(1, 8'h00, 8'h00, 0);
    apb(1, 8'h04, 8'h00, 0);
    apb(1, 8'h08, 8'h00, 0);
    ext_pin <= 1'b0;
  endtask
  task report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {ext_pin, overtemp_in, ev} = 10'h0;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs;
    t_edges;
    t_thermal;
    t_events;
    t_service;
    t_reset;
    t_prio;
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    report_and_stop;
  end
endmodule // interrupt_flag_enable_bank_test

// ==== verif/irq_bank_assertions.sv ====
module irq_bank_assertions (
  input logic        core_clk,
  input logic        sys_rst,
  input logic        psel,
  input logic        penable,
  input logic [7:0]  paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        tick0_evt,
  input logic        irq_ack,
  input logic        irq_req,
  input logic [2:0]  irq_index,
  input logic        wake_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_service; irq_req && irq_ack; endsequence
  a_ready_next: assert property (s_setup |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_bad_addr: assert property (psel && !penable && paddr > 8'h14 |=> pslverr)
    else $error("no error on unmapped");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits");
  a_ack_drops: assert property (s_service |=> !irq_req) else $error("req after ack");
  a_index_hold: assert property (irq_req && !irq_ack |=> !irq_req || $stable(irq_index))
    else $error("index moved");
  a_index_range: assert property (irq_req |-> irq_index <= 3'd6) else $error("bad index");
  a_req_wake: assert property (irq_req |-> wake_req) else $error("req without wake");
  a_tick_wake: assert property (tick0_evt |-> ##2 wake_req) else $error("no wake");
endmodule // irq_bank_assertions

bind irq_bank irq_bank_assertions u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tick0_evt(tick0_evt), .irq_ack(irq_ack), .irq_req(irq_req), .irq_index(irq_index),
  .wake_req(wake_req));

// ==== verif/irq_core_model.sv ====
module irq_core_model #(parameter int ACK_DELAY = 2) (
  input  logic       core_clk,
  input  logic       sys_rst,
  input  logic       irq_req,
  input  logic [2:0] irq_index,
  output logic       irq_ack,
  output logic [2:0] last_index
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // one service pulse per request, after a programmable latency
  always @(posedge core_clk) begin
    if (sys_rst) begin
      irq_ack    <= 1'b0;
      last_index <= 3'h0;
      cnt        <= 0;
    end else begin
      irq_ack <= 1'b0;
      if (irq_req && !irq_ack) begin
        if (cnt == ACK_DELAY) begin
          irq_ack    <= 1'b1;
          last_index <= irq_index;
          cnt        <= 0;
        end else cnt <= cnt + 1;
      end else cnt <= 0;
    end
  end
endmodule // irq_core_model
